//--- hdl/fault_limits_cfg.svh
/*
   offsets, field positions, reset values and timing counts for the fault-limit block.
   assumes a 10 MHz system clock and a command decoder that hands over command codes.
*/
// What this block does
// - command 46h holds the writable overcurrent fault limit, default 125% of max current
// - limits split into 5-bit signed exponent 15:11 and 11-bit signed mantissa 10:0
// - overcurrent fault sets summary, word and current status bits and raises alert
// - command 47h reads constant FAh fault action, writes are ignored
// - overcurrent fault disables output at once, restart tried after 22 ms
// - command 4Ah holds the writable overcurrent warning limit, default max current
// - overcurrent warning sets other, current word and warning bits and raises alert
// - command 4Fh holds writable over-temperature fault limit, reset 007Dh
// - over-temperature fault sets temperature bits, raises alert and regulator fault
// - after over-temperature shutdown re-enable only at more than 15 C below the limit
`ifndef FAULT_LIMITS_CFG_SVH
`define FAULT_LIMITS_CFG_SVH

// ==========================================
// command codes
`define CMD_OC_FAULT_LIMIT  8'h46
`define CMD_OC_FAULT_ACTION 8'h47
`define CMD_OC_WARN_LIMIT   8'h4A
`define CMD_OVERTEMP_FAULT_THRESHOLD  8'h4F

// ==========================================
// field layout and reset values
`define EXP_MSB             15
`define EXP_LSB             11
`define MANT_MSB            10
`define OC_ACTION_VALUE     8'hFA
`define OT_LIMIT_RESET      16'h007D
`define FIXED_FRAC          16

// ==========================================
// status bit positions
`define SB_IOUT_OC          4
`define SB_TEMP             2
`define SB_OTHER            0
`define SW_IOUT             14
`define SI_OC_FAULT         7
`define SI_OC_WARN          5
`define ST_OT_FAULT         7

// ==========================================
// timing
`define CLK_KHZ             10000
`define RETRY_MS            22
`define OT_HYST_C           15

`endif

//--- hdl/fault_limits_pkg.sv
/*
   types shared by the fault-limit block.
   assumes nothing of its surroundings.
*/
package fault_limits_pkg;
   typedef enum logic [1:0] {st_run, st_oc_retry, st_ot_cool} power_state_type;
   typedef logic signed [47:0] fixed_type;
endpackage

//--- hdl/linear_compare.sv
/*
   decodes two linear-format words to fixed point and compares them on a sample pulse.
   assumes inputs are stable and synchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "fault_limits_cfg.svh"

module linear_compare (
   input  wire logic                        sys_clk,
   input  wire logic                        nrst,
   input  wire logic                        sample,
   input  wire logic [15:0]                 meas,
   input  wire logic [15:0]                 limit,
   input  wire fault_limits_pkg::fixed_type hyst,
   output      logic                        above,
   output      logic                        below
);
   fault_limits_pkg::fixed_type meas_fixed;
   fault_limits_pkg::fixed_type limit_fixed;

   // ==========================================
   // linear decode
   // exponent and mantissa scaling
   function automatic fault_limits_pkg::fixed_type to_fixed(input logic [15:0] v);
      logic [4:0] shamt;
      shamt = {~v[`EXP_MSB], v[`EXP_MSB-1:`EXP_LSB]};
      return $signed({{37{v[`MANT_MSB]}}, v[`MANT_MSB:0]}) <<< shamt;
   endfunction

   assign meas_fixed  = to_fixed(meas);
   assign limit_fixed = to_fixed(limit);

   // ==========================================
   // compare on each update
   // threshold crossing check
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         above <= 1'b0;
         below <= 1'b0;
      end else if (sample) begin
         above <= meas_fixed > limit_fixed;
         below <= meas_fixed < (limit_fixed - hyst);
      end
   end

   a_unity_scale: assert property (@(posedge sys_clk) disable iff (!nrst)
      limit[`EXP_MSB:`EXP_LSB] == 5'h00 |->
         limit_fixed == ($signed({{37{limit[10]}}, limit[10:0]}) <<< `FIXED_FRAC))
      else $error("linear decode scale wrong");

   a_compare_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      !sample |=> $stable(above) && $stable(below))
      else $error("compare changed without sample");
endmodule // linear_compare

//--- hdl/fault_limits.sv
/*
   overcurrent and over-temperature limit registers, status bits and shutdown/restart.
   assumes a command decoder gives one-cycle read and write strobes, and telemetry
   words plus their update strobe come from logic on sys_clk.
*/
`timescale 1ns/1ps
`include "fault_limits_cfg.svh"

module fault_limits #(
   parameter int MS_CYCLES = `CLK_KHZ
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_wr,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        cmd_rd,
   output      logic [15:0] cmd_rdata,
   output      logic        cmd_rvalid,
   input  wire logic        status_clear,
   input  wire logic [15:0] max_current_setting,
   input  wire logic        telem_update,
   input  wire logic [15:0] meas_current,
   input  wire logic [15:0] meas_temp,
   output      logic [7:0]  status_byte,
   output      logic [15:0] status_word,
   output      logic [7:0]  status_current,
   output      logic [7:0]  status_temp,
   output      logic        host_alert_output,
   output      logic        regulator_fault_output,
   output      logic        output_enable
);
   logic [15:0]                      oc_fault_limit;
   logic [15:0]                      oc_warn_limit;
   logic [15:0]                      overtemp_fault_threshold;
   logic                             defaults_loaded;
   logic                             update_seen;
   logic                             oc_above;
   logic                             warn_above;
   logic                             ot_above;
   logic                             ot_cool;
   logic                             oc_trip;
   logic                             warn_trip;
   logic                             ot_trip;
   logic                             ms_tick;
   logic                             retry_done;
   logic [23:0]                      ms_cnt;
   logic [7:0]                       retry_cnt;
   fault_limits_pkg::power_state_type state;
   fault_limits_pkg::power_state_type next_state;
   logic [4:0]                       oc_fault_exp_field;
   logic [10:0]                      oc_fault_mant_field;
   logic [4:0]                       oc_warn_exp_field;
   logic [10:0]                      oc_warn_mant_field;
   logic [4:0]                       temp_fault_exp_field;
   logic [10:0]                      temp_fault_mant_field;

   // ==========================================
   // field views
   assign {oc_fault_exp_field, oc_fault_mant_field}     = oc_fault_limit;
   assign {oc_warn_exp_field, oc_warn_mant_field}       = oc_warn_limit;
   assign {temp_fault_exp_field, temp_fault_mant_field} = overtemp_fault_threshold;

   // ==========================================
   // 125 percent of a linear value
   function automatic logic [15:0] scale_125(input logic [15:0] v);
      logic signed [13:0] m5;
      logic signed [13:0] t;
      logic [15:0]        r;
      m5 = $signed({{3{v[`MANT_MSB]}}, v[`MANT_MSB:0]}) * 14'sd5;
      r  = v;
      for (int s = 3; s >= 0; s--) begin
         t = m5 >>> s;
         if (t[13:10] == {4{t[10]}}) begin
            r = {5'(v[`EXP_MSB:`EXP_LSB] + 5'(s) - 5'd2), t[10:0]};
         end
      end
      return r;
   endfunction

   // ==========================================
   // limit registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         oc_fault_limit  <= 16'h0000;
         oc_warn_limit   <= 16'h0000;
         overtemp_fault_threshold  <= `OT_LIMIT_RESET;
         defaults_loaded <= 1'b0;
      end else if (!defaults_loaded) begin
         oc_fault_limit  <= scale_125(max_current_setting);
         oc_warn_limit   <= max_current_setting;
         defaults_loaded <= 1'b1;
      end else if (cmd_wr) begin
         if (cmd_code == `CMD_OC_FAULT_LIMIT) begin
            oc_fault_limit <= cmd_wdata;
         end else if (cmd_code == `CMD_OC_WARN_LIMIT) begin
            oc_warn_limit <= cmd_wdata;
         end else if (cmd_code == `CMD_OVERTEMP_FAULT_THRESHOLD) begin
            overtemp_fault_threshold <= cmd_wdata;
         end
      end
   end

   // ==========================================
   // read port
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_rdata  <= 16'h0000;
         cmd_rvalid <= 1'b0;
      end else begin
         cmd_rvalid <= cmd_rd;
         if (cmd_rd) begin
            if (cmd_code == `CMD_OC_FAULT_LIMIT) begin
               cmd_rdata <= oc_fault_limit;
            end else if (cmd_code == `CMD_OC_FAULT_ACTION) begin
               cmd_rdata <= {8'h00, `OC_ACTION_VALUE};
            end else if (cmd_code == `CMD_OC_WARN_LIMIT) begin
               cmd_rdata <= oc_warn_limit;
            end else if (cmd_code == `CMD_OVERTEMP_FAULT_THRESHOLD) begin
               cmd_rdata <= overtemp_fault_threshold;
            end else begin
               cmd_rdata <= 16'h0000;
            end
         end
      end
   end

   // ==========================================
   // comparators
   linear_compare u_oc_cmp (
      .sys_clk(sys_clk), .nrst(nrst), .sample(telem_update), .meas(meas_current),
      .limit({oc_fault_exp_field, oc_fault_mant_field}), .hyst('0), .above(oc_above),
      .below());
   linear_compare u_warn_cmp (
      .sys_clk(sys_clk), .nrst(nrst), .sample(telem_update), .meas(meas_current),
      .limit({oc_warn_exp_field, oc_warn_mant_field}), .hyst('0), .above(warn_above),
      .below());
   linear_compare u_ot_cmp (
      .sys_clk(sys_clk), .nrst(nrst), .sample(telem_update), .meas(meas_temp),
      .limit({temp_fault_exp_field, temp_fault_mant_field}),
      .hyst(48'(`OT_HYST_C) <<< `FIXED_FRAC), .above(ot_above), .below(ot_cool));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         update_seen <= 1'b0;
      end else begin
         update_seen <= telem_update;
      end
   end

   assign oc_trip   = update_seen && oc_above;
   assign warn_trip = update_seen && warn_above;
   assign ot_trip   = update_seen && ot_above;

   // ==========================================
   // status bits, set wins over clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_byte    <= 8'h00;
         status_word    <= 16'h0000;
         status_current <= 8'h00;
         status_temp    <= 8'h00;
      end else begin
         if (status_clear) begin
            status_byte    <= 8'h00;
            status_word    <= 16'h0000;
            status_current <= 8'h00;
            status_temp    <= 8'h00;
         end
         if (oc_trip) begin
            status_byte[`SB_IOUT_OC]     <= 1'b1;
            status_word[`SB_IOUT_OC]     <= 1'b1;
            status_word[`SW_IOUT]        <= 1'b1;
            status_current[`SI_OC_FAULT] <= 1'b1;
         end
         if (warn_trip) begin
            status_byte[`SB_OTHER]      <= 1'b1;
            status_word[`SB_OTHER]      <= 1'b1;
            status_word[`SW_IOUT]       <= 1'b1;
            status_current[`SI_OC_WARN] <= 1'b1;
         end
         if (ot_trip) begin
            status_byte[`SB_TEMP]     <= 1'b1;
            status_word[`SB_TEMP]     <= 1'b1;
            status_temp[`ST_OT_FAULT] <= 1'b1;
         end
      end
   end

   assign host_alert_output      = |{status_byte, status_current, status_temp};
   assign regulator_fault_output = status_temp[`ST_OT_FAULT];

   // ==========================================
   // retry timer
   assign ms_tick    = (ms_cnt == 24'(MS_CYCLES - 1));
   assign retry_done = (state == fault_limits_pkg::st_oc_retry) && ms_tick &&
                       (retry_cnt == 8'(`RETRY_MS - 1));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ms_cnt    <= 24'h000000;
         retry_cnt <= 8'h00;
      end else if (state != fault_limits_pkg::st_oc_retry) begin
         ms_cnt    <= 24'h000000;
         retry_cnt <= 8'h00;
      end else if (ms_tick) begin
         ms_cnt    <= 24'h000000;
         retry_cnt <= retry_cnt + 8'h01;
      end else begin
         ms_cnt <= ms_cnt + 24'h000001;
      end
   end

   // ==========================================
   // output state machine
   always_comb begin
      next_state = state;
      case (state)
         fault_limits_pkg::st_run: begin
            if (ot_trip) begin
               next_state = fault_limits_pkg::st_ot_cool;
            end else if (oc_trip) begin
               next_state = fault_limits_pkg::st_oc_retry;
            end
         end
         fault_limits_pkg::st_oc_retry: begin
            if (ot_trip) begin
               next_state = fault_limits_pkg::st_ot_cool;
            end else if (retry_done) begin
               next_state = fault_limits_pkg::st_run;
            end
         end
         fault_limits_pkg::st_ot_cool: begin
            if (update_seen && ot_cool) begin
               next_state = fault_limits_pkg::st_run;
            end
         end
         default: next_state = fault_limits_pkg::st_run;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state         <= fault_limits_pkg::st_run;
         output_enable <= 1'b1;
      end else begin
         state         <= next_state;
         output_enable <= (next_state == fault_limits_pkg::st_run);
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_oc_trip;
      oc_trip && !ot_trip && state == fault_limits_pkg::st_run;
   endsequence
   sequence s_off_waiting;
      !output_enable [*8];
   endsequence
   a_oc_fault_write: assert property (defaults_loaded && cmd_wr &&
      cmd_code == `CMD_OC_FAULT_LIMIT |=> oc_fault_limit == $past(cmd_wdata))
      else $error("fault limit write lost");
   a_oc_status_set: assert property (oc_trip |=> status_byte[`SB_IOUT_OC] &&
      status_word[`SW_IOUT] && status_current[`SI_OC_FAULT] && host_alert_output)
      else $error("overcurrent status missing");
   a_action_read: assert property (cmd_rd &&
      cmd_code == `CMD_OC_FAULT_ACTION |=> cmd_rvalid && cmd_rdata == 16'h00FA)
      else $error("action byte wrong");
   a_oc_shutdown: assert property (s_oc_trip |=> s_off_waiting)
      else $error("output not held off after overcurrent");
   a_retry_restart: assert property ($rose(output_enable) |->
      $past(retry_done) || $past(state == fault_limits_pkg::st_ot_cool))
      else $error("restart without cause");
   a_warn_default: assert property ($rose(defaults_loaded) |->
      oc_warn_limit == $past(max_current_setting))
      else $error("warning default wrong");
   a_warn_status_set: assert property (warn_trip |=> status_byte[`SB_OTHER] &&
      status_current[`SI_OC_WARN] && status_word[`SW_IOUT] && host_alert_output)
      else $error("warning status missing");
   a_ot_status_set: assert property (ot_trip |=> status_temp[`ST_OT_FAULT] &&
      status_byte[`SB_TEMP] && regulator_fault_output && !output_enable)
      else $error("over-temperature response missing");
   a_ot_hold_off: assert property (state == fault_limits_pkg::st_ot_cool &&
      !(update_seen && ot_cool) |=> !output_enable)
      else $error("output back on before cooling");
endmodule // fault_limits

//--- tb/host_model.sv
/*
   host controller model: issues limit writes, limit reads and status clears.
   assumes the block takes one-cycle strobes and answers a read with a one-cycle valid.
*/
`timescale 1ns/1ps

module host_model (
   input  wire logic        sys_clk,
   output      logic [7:0]  cmd_code,
   output      logic        cmd_wr,
   output      logic [15:0] cmd_wdata,
   output      logic        cmd_rd,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_rvalid,
   output      logic        status_clear
);
   // ==========================================
   // idle levels
   initial begin
      cmd_code     = 8'h00;
      cmd_wr       = 1'b0;
      cmd_wdata    = 16'h0000;
      cmd_rd       = 1'b0;
      status_clear = 1'b0;
   end

   // ==========================================
   // command cycles, driven on the falling edge
   task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
      @(negedge sys_clk);
      cmd_code  = code;
      cmd_wdata = data;
      cmd_wr    = 1'b1;
      @(negedge sys_clk);
      cmd_wr    = 1'b0;
      cmd_wdata = ~data;
   endtask

   task automatic read_cmd(input logic [7:0] code, output logic [15:0] data,
                           output logic ok);
      int i;
      @(negedge sys_clk);
      cmd_code = code;
      cmd_rd   = 1'b1;
      @(negedge sys_clk);
      cmd_rd   = 1'b0;
      ok       = 1'b0;
      data     = 16'h0000;
      for (i = 0; i < 4; i++) begin
         if (!ok && cmd_rvalid === 1'b1) begin
            data = cmd_rdata;
            ok   = 1'b1;
         end
         if (!ok) begin
            @(negedge sys_clk);
         end
      end
   endtask

   task automatic clear_status;
      @(negedge sys_clk);
      status_clear = 1'b1;
      @(negedge sys_clk);
      status_clear = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask
endmodule // host_model

//--- tb/fault_limits_tb_top.sv
/*
   self-checking bench for the fault-limit block: limits, status, shutdown and restart.
   assumes a 10 MHz clock and a shortened millisecond count.
*/
`timescale 1ns/1ps
`include "fault_limits_cfg.svh"

module fault_limits_tb_top;
   localparam int MS    = 10;
   localparam int RETRY = `RETRY_MS * MS;

   logic        sys_clk;
   logic        nrst;
   logic [7:0]  cmd_code;
   logic        cmd_wr;
   logic [15:0] cmd_wdata;
   logic        cmd_rd;
   logic [15:0] cmd_rdata;
   logic        cmd_rvalid;
   logic        status_clear;
   logic [15:0] max_current_setting;
   logic        telem_update;
   logic [15:0] meas_current;
   logic [15:0] meas_temp;
   logic [7:0]  status_byte;
   logic [15:0] status_word;
   logic [7:0]  status_current;
   logic [7:0]  status_temp;
   logic        host_alert_output;
   logic        regulator_fault_output;
   logic        output_enable;
   int          fails     = 0;
   int          tests_run = 0;
   int          cycles    = 0;

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   fault_limits #(.MS_CYCLES(MS)) dut (
      .sys_clk(sys_clk), .nrst(nrst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
      .cmd_rvalid(cmd_rvalid), .status_clear(status_clear),
      .max_current_setting(max_current_setting), .telem_update(telem_update),
      .meas_current(meas_current), .meas_temp(meas_temp), .status_byte(status_byte),
      .status_word(status_word), .status_current(status_current),
      .status_temp(status_temp), .host_alert_output(host_alert_output),
      .regulator_fault_output(regulator_fault_output), .output_enable(output_enable));

   host_model host (
      .sys_clk(sys_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .status_clear(status_clear));

   // ==========================================
   // compare and report
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s is %b", $time, what, got);
      end
   endtask

   task automatic complete_run;
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         complete_run();
      end
   end

   // ==========================================
   // shared steps
   task automatic read_expect(input logic [7:0] code, input logic [15:0] exp);
      logic [15:0] data;
      logic        ok;
      host.read_cmd(code, data, ok);
      check_bit(ok, 1'b1, "read answer");
      check_word(data, exp);
   endtask

   task automatic telem(input logic [15:0] cur, input logic [15:0] tmp);
      @(negedge sys_clk);
      meas_current = cur;
      meas_temp    = tmp;
      telem_update = 1'b1;
      @(negedge sys_clk);
      telem_update = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic wait_enable(output int count);
      count = 0;
      while (output_enable !== 1'b1 && count < RETRY + 20) begin
         @(negedge sys_clk);
         count++;
      end
   endtask

   // ==========================================
   // scenarios
   task automatic test_defaults;
      read_expect(`CMD_OVERTEMP_FAULT_THRESHOLD, 16'h007D);
      read_expect(`CMD_OC_FAULT_ACTION, 16'h00FA);
      read_expect(`CMD_OC_WARN_LIMIT, 16'h0010);
      read_expect(`CMD_OC_FAULT_LIMIT, 16'hF050);
      read_expect(8'h33, 16'h0000);
      check_bit(host_alert_output, 1'b0, "alert");
      check_bit(output_enable, 1'b1, "enable");
   endtask

   task automatic test_warning;
      telem(16'h0011, 16'h0019);
      check_bit(status_current[`SI_OC_WARN], 1'b1, "warn bit");
      check_bit(status_byte[`SB_OTHER], 1'b1, "other bit");
      check_bit(status_word[`SW_IOUT], 1'b1, "word current");
      check_bit(status_current[`SI_OC_FAULT], 1'b0, "fault bit");
      check_bit(host_alert_output, 1'b1, "alert");
      check_bit(output_enable, 1'b1, "enable");
      host.clear_status();
      check_bit(host_alert_output, 1'b0, "alert");
   endtask

   task automatic test_fault_retry;
      int n;
      telem(16'h0014, 16'h0019);
      check_bit(status_current[`SI_OC_FAULT], 1'b0, "fault at limit");
      telem(16'h0015, 16'h0019);
      check_bit(status_current[`SI_OC_FAULT], 1'b1, "fault bit");
      check_bit(status_byte[`SB_IOUT_OC], 1'b1, "byte fault");
      check_bit(status_word[`SW_IOUT], 1'b1, "word current");
      check_bit(host_alert_output, 1'b1, "alert");
      check_bit(output_enable, 1'b0, "enable off");
      wait_enable(n);
      check_bit(n >= RETRY - 6 && n <= RETRY + 2, 1'b1, "retry delay");
      host.clear_status();
   endtask

   task automatic test_write_decode;
      int n;
      host.write_cmd(`CMD_OC_FAULT_LIMIT, 16'hF828);
      host.write_cmd(`CMD_OC_FAULT_ACTION, 16'h0000);
      host.write_cmd(`CMD_OC_WARN_LIMIT, 16'h0123);
      read_expect(`CMD_OC_FAULT_LIMIT, 16'hF828);
      read_expect(`CMD_OC_FAULT_ACTION, 16'h00FA);
      read_expect(`CMD_OC_WARN_LIMIT, 16'h0123);
      telem(16'h080A, 16'h0019);
      check_bit(status_current[`SI_OC_FAULT], 1'b0, "equal scaled");
      telem(16'h080B, 16'h0019);
      check_bit(status_current[`SI_OC_FAULT], 1'b1, "above scaled");
      check_bit(output_enable, 1'b0, "enable off");
      wait_enable(n);
      check_bit(n >= RETRY - 6 && n <= RETRY + 2, 1'b1, "retry delay");
      host.clear_status();
   endtask

   task automatic test_overtemp;
      host.write_cmd(`CMD_OVERTEMP_FAULT_THRESHOLD, 16'h0064);
      read_expect(`CMD_OVERTEMP_FAULT_THRESHOLD, 16'h0064);
      telem(16'h0000, 16'h0064);
      check_bit(status_temp[`ST_OT_FAULT], 1'b0, "temp at limit");
      telem(16'h0000, 16'h0065);
      check_bit(status_temp[`ST_OT_FAULT], 1'b1, "temp bit");
      check_bit(status_byte[`SB_TEMP], 1'b1, "byte temp");
      check_bit(host_alert_output, 1'b1, "alert");
      check_bit(regulator_fault_output, 1'b1, "reg fault");
      check_bit(output_enable, 1'b0, "enable off");
      telem(16'h0000, 16'h0055);
      check_bit(output_enable, 1'b0, "still cooling");
      telem(16'h0000, 16'h0054);
      check_bit(output_enable, 1'b1, "enable back");
      host.clear_status();
      check_bit(regulator_fault_output, 1'b0, "reg fault clear");
   endtask

   task automatic test_reset_again;
      telem(16'h0200, 16'h0019);
      check_bit(host_alert_output, 1'b1, "alert before reset");
      check_bit(output_enable, 1'b0, "enable before reset");
      nrst = 1'b0;
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (2) @(negedge sys_clk);
      check_bit(host_alert_output, 1'b0, "alert after reset");
      check_bit(output_enable, 1'b1, "enable after reset");
      read_expect(`CMD_OVERTEMP_FAULT_THRESHOLD, 16'h007D);
      read_expect(`CMD_OC_WARN_LIMIT, 16'h0010);
   endtask

   // ==========================================
   // main sequence
   initial begin
      nrst                = 1'b0;
      max_current_setting = 16'h0010;
      telem_update        = 1'b0;
      meas_current        = 16'h0000;
      meas_temp           = 16'h0019;
      repeat (16) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (3) @(negedge sys_clk);
      test_defaults();
      test_warning();
      test_fault_retry();
      test_write_decode();
      test_overtemp();
      test_reset_again();
      complete_run();
   end
endmodule // fault_limits_tb_top
